//--- ats_params.svh
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

// timing base: the clock period and the millisecond tick, both in picoseconds
`define CLK_PERIOD_PS 4000
`define TICK_PERIOD_PS 1000000000
`define TICK_CYCLES (`TICK_PERIOD_PS / `CLK_PERIOD_PS)

// delays counted in millisecond ticks
`define DELAY_W 16
`define CMD_TIMEOUT_MS 500
`define PARALLEL_DWELL_MS 100

`endif

//--- ats_pkg.sv
package ats_pkg;

   typedef enum logic [1:0] {TRIP_NONE, TRIP_A, TRIP_B, TRIP_TIE} trip_sel_e;

   typedef enum logic [1:0] {TEST_NORMAL, TEST_EMULATE_A_LOSS, TEST_EMULATE_B_LOSS,
      TEST_SPARE} test_sel_e;

   typedef enum logic [1:0] {BRK_A, BRK_B, BRK_TIE} brk_e;

   typedef enum {
      S_IDLE, S_NORMAL, S_LOSS_TRIP, S_LOSS_TIE, S_TRANSFERRED, S_RET_TIE_OPEN,
      S_RET_SRC_CLOSE, S_PAR_CLOSE, S_PARALLEL, S_PAR_TRIP_SRC, S_PAR_TRIP_TIE,
      S_MAINT, S_FAULT
   } seq_state_e;

endpackage

//--- breaker_if.sv
`timescale 1ns/1ps
interface breaker_if;
   logic start;
   logic close_op;
   logic done;
   logic fail;

   modport seq
   (
      output start,
      output close_op,
      input done,
      input fail
   );

   modport drv
   (
      input start,
      input close_op,
      output done,
      output fail
   );
endinterface

//--- delay_timer.sv
`timescale 1ns/1ps
module delay_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic expired
);
   logic [W-1:0] count;
   wire at_limit = (count >= limit);

   // the count starts over whenever the timed condition drops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         count <= '0;
      else if (!run)
         count <= '0;
      else if (tick && !at_limit)
         count <= count + 1'b1;
   end

   assign expired = run && at_limit;
endmodule

//--- breaker_cmd.sv
`timescale 1ns/1ps
module breaker_cmd #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   breaker_if.drv req,
   input wire logic closed,
   input wire logic close_permit,
   input wire logic abort,
   input wire logic tick,
   input wire logic [W-1:0] timeout,
   output logic close_cmd,
   output logic trip_cmd
);
   logic busy;
   logic op_close;
   logic [W-1:0] count;

   wire reached = busy && (closed == op_close);
   wire expired = busy && (count >= timeout);
   wire hold = busy && !reached && !expired && !abort;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy <= 1'b0;
         op_close <= 1'b0;
         count <= '0;
      end
      else if (abort)
         busy <= 1'b0;
      else if (req.start)
      begin
         busy <= 1'b1;
         op_close <= req.close_op;
         count <= '0;
      end
      else if (reached || expired)
         busy <= 1'b0;
      else if (busy && tick)
         count <= count + 1'b1;
   end

   // coil commands are levels held until the position switch agrees, the timeout expires or abort rises
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         close_cmd <= 1'b0;
         trip_cmd <= 1'b0;
      end
      else
      begin
         close_cmd <= hold && op_close && close_permit;
         trip_cmd <= hold && !op_close;
      end
   end

   assign req.done = reached;
   assign req.fail = expired && !reached;
endmodule

//--- auto_transfer_sequencer.sv
`timescale 1ns/1ps
`include "ats_params.svh"
module auto_transfer_sequencer #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int W = `DELAY_W,
   parameter logic [W-1:0] CMD_TIMEOUT_MS = W'(`CMD_TIMEOUT_MS),
   parameter logic [W-1:0] PARALLEL_DWELL_MS = W'(`PARALLEL_DWELL_MS)
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic auto_mode,
   input wire logic source_a_ok,
   input wire logic source_b_ok,
   input wire logic source_a_breaker_closed,
   input wire logic source_b_breaker_closed,
   input wire logic tie_breaker_closed,
   input wire logic source_a_breaker_tripped,
   input wire logic source_b_breaker_tripped,
   input wire logic tie_breaker_tripped,
   input wire logic source_a_breaker_connected,
   input wire logic source_b_breaker_connected,
   input wire logic tie_breaker_connected,
   input wire logic redundant_tie_fitted,
   input wire logic redundant_tie_connected,
   input wire logic redundant_tie_tripped,
   input wire logic sync_check_fitted,
   input wire logic sync_ok,
   input wire logic closed_transition,
   input wire logic manual_return,
   input wire logic return_request,
   input wire ats_pkg::trip_sel_e trip_sel,
   input wire ats_pkg::test_sel_e test_sel,
   input wire logic [W-1:0] transfer_delay_ms,
   input wire logic [W-1:0] return_delay_ms,
   output logic source_a_close,
   output logic source_a_trip,
   output logic source_b_close,
   output logic source_b_trip,
   output logic tie_close,
   output logic tie_trip,
   output logic transfer_blocked,
   output logic auto_active,
   output logic transferred,
   output logic paralleled,
   output logic fault_alarm
);
   import ats_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   seq_state_e state;
   seq_state_e next_state;
   logic lost_b;
   logic next_lost_b;
   logic req_valid;
   logic next_req_valid;
   brk_e req_brk;
   brk_e next_req_brk;
   logic req_close;
   logic next_req_close;
   logic [TW-1:0] prescale;
   logic tick;
   logic xfer_due;
   logic ret_due;
   logic dwell_due;

   breaker_if if_a();
   breaker_if if_b();
   breaker_if if_t();

   // millisecond tick shared by every timer
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         prescale <= '0;
      else if (prescale == TICK_LAST)
         prescale <= '0;
      else
         prescale <= prescale + 1'b1;
   end
   assign tick = (prescale == TICK_LAST);

   // availability already merges undervoltage and phase-loss relays upstream
   wire avail_a = source_a_ok && (test_sel != TEST_EMULATE_A_LOSS);
   wire avail_b = source_b_ok && (test_sel != TEST_EMULATE_B_LOSS);
   wire lost_a_now = !avail_a && avail_b;
   wire lost_b_now = !avail_b && avail_a;

   // the redundant coupling breaker has no command path at all
   wire redundant_bad = redundant_tie_fitted &&
      (!redundant_tie_connected || redundant_tie_tripped);
   wire lockout = source_a_breaker_tripped || source_b_breaker_tripped ||
      tie_breaker_tripped;
   wire withdrawn = !source_a_breaker_connected || !source_b_breaker_connected ||
      !tie_breaker_connected;
   wire blocked = lockout || withdrawn || redundant_bad;
   wire abort = !auto_mode || blocked;

   wire sync_par = sync_check_fitted && sync_ok;
   wire normal_lineup = source_a_breaker_closed && source_b_breaker_closed &&
      !tie_breaker_closed;
   wire all_closed = source_a_breaker_closed && source_b_breaker_closed &&
      tie_breaker_closed;

   // paralleling all three is refused unless synchronism is confirmed
   wire permit_a = !(source_b_breaker_closed && tie_breaker_closed) || sync_par;
   wire permit_b = !(source_a_breaker_closed && tie_breaker_closed) || sync_par;
   wire permit_t = !(source_a_breaker_closed && source_b_breaker_closed) || sync_par;

   wire src_avail = lost_b ? avail_b : avail_a;
   brk_e src_brk;
   assign src_brk = lost_b ? BRK_B : BRK_A;

   wire sel_done = (req_brk == BRK_A) ? if_a.done :
      (req_brk == BRK_B) ? if_b.done : if_t.done;
   wire sel_fail = (req_brk == BRK_A) ? if_a.fail :
      (req_brk == BRK_B) ? if_b.fail : if_t.fail;

   assign if_a.start = req_valid && (req_brk == BRK_A);
   assign if_b.start = req_valid && (req_brk == BRK_B);
   assign if_t.start = req_valid && (req_brk == BRK_TIE);
   assign if_a.close_op = req_close;
   assign if_b.close_op = req_close;
   assign if_t.close_op = req_close;

   delay_timer #(.W(W)) u_xfer_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .run((state == S_NORMAL) && (lost_a_now || lost_b_now)),
      .tick(tick),
      .limit(transfer_delay_ms),
      .expired(xfer_due)
   );

   delay_timer #(.W(W)) u_ret_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .run((state == S_TRANSFERRED) && src_avail),
      .tick(tick),
      .limit(return_delay_ms),
      .expired(ret_due)
   );

   delay_timer #(.W(W)) u_dwell_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(state == S_PARALLEL),
      .tick(tick),
      .limit(PARALLEL_DWELL_MS),
      .expired(dwell_due)
   );

   breaker_cmd #(.W(W)) u_cmd_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(if_a),
      .closed(source_a_breaker_closed),
      .close_permit(permit_a),
      .abort(abort),
      .tick(tick),
      .timeout(CMD_TIMEOUT_MS),
      .close_cmd(source_a_close),
      .trip_cmd(source_a_trip)
   );

   breaker_cmd #(.W(W)) u_cmd_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(if_b),
      .closed(source_b_breaker_closed),
      .close_permit(permit_b),
      .abort(abort),
      .tick(tick),
      .timeout(CMD_TIMEOUT_MS),
      .close_cmd(source_b_close),
      .trip_cmd(source_b_trip)
   );

   breaker_cmd #(.W(W)) u_cmd_t (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(if_t),
      .closed(tie_breaker_closed),
      .close_permit(permit_t),
      .abort(abort),
      .tick(tick),
      .timeout(CMD_TIMEOUT_MS),
      .close_cmd(tie_close),
      .trip_cmd(tie_trip)
   );

   always_comb
   begin
      next_state = state;
      next_lost_b = lost_b;
      next_req_valid = 1'b0;
      next_req_brk = req_brk;
      next_req_close = req_close;
      case (state)
         S_IDLE:
         begin
            // automatic operation only picks up from the normal lineup
            if (normal_lineup)
               next_state = S_NORMAL;
         end
         S_NORMAL:
         begin
            if (xfer_due)
            begin
               next_lost_b = !lost_a_now;
               next_req_valid = 1'b1;
               next_req_brk = lost_a_now ? BRK_A : BRK_B;
               next_req_close = 1'b0;
               next_state = S_LOSS_TRIP;
            end
            else if ((trip_sel == TRIP_A || trip_sel == TRIP_B) && sync_par)
            begin
               next_lost_b = (trip_sel == TRIP_B);
               next_req_valid = 1'b1;
               next_req_brk = BRK_TIE;
               next_req_close = 1'b1;
               next_state = S_PAR_CLOSE;
            end
         end
         S_LOSS_TRIP:
         begin
            if (sel_done)
            begin
               next_req_valid = 1'b1;
               next_req_brk = BRK_TIE;
               next_req_close = 1'b1;
               next_state = S_LOSS_TIE;
            end
         end
         S_LOSS_TIE:
         begin
            if (sel_done)
               next_state = S_TRANSFERRED;
         end
         S_TRANSFERRED:
         begin
            if (manual_return)
            begin
               // a manual return never parallels the sources
               if (return_request && src_avail)
               begin
                  next_req_valid = 1'b1;
                  next_req_brk = BRK_TIE;
                  next_req_close = 1'b0;
                  next_state = S_RET_TIE_OPEN;
               end
            end
            else if (ret_due && closed_transition)
            begin
               if (sync_par)
               begin
                  next_req_valid = 1'b1;
                  next_req_brk = src_brk;
                  next_req_close = 1'b1;
                  next_state = S_PAR_CLOSE;
               end
            end
            else if (ret_due)
            begin
               next_req_valid = 1'b1;
               next_req_brk = BRK_TIE;
               next_req_close = 1'b0;
               next_state = S_RET_TIE_OPEN;
            end
         end
         S_RET_TIE_OPEN:
         begin
            if (sel_done)
            begin
               next_req_valid = 1'b1;
               next_req_brk = src_brk;
               next_req_close = 1'b1;
               next_state = S_RET_SRC_CLOSE;
            end
         end
         S_PAR_CLOSE:
         begin
            if (sel_done)
               next_state = S_PARALLEL;
         end
         S_PARALLEL:
         begin
            // whichever breaker the selector names leaves the parallel
            if (dwell_due && (trip_sel == TRIP_A || trip_sel == TRIP_B))
            begin
               next_lost_b = (trip_sel == TRIP_B);
               next_req_valid = 1'b1;
               next_req_brk = (trip_sel == TRIP_B) ? BRK_B : BRK_A;
               next_req_close = 1'b0;
               next_state = S_PAR_TRIP_SRC;
            end
            else if (dwell_due)
            begin
               next_req_valid = 1'b1;
               next_req_brk = BRK_TIE;
               next_req_close = 1'b0;
               next_state = S_PAR_TRIP_TIE;
            end
         end
         S_PAR_TRIP_SRC:
         begin
            if (sel_done)
               next_state = S_MAINT;
         end
         S_MAINT:
         begin
            if (trip_sel == TRIP_TIE && sync_par)
            begin
               next_req_valid = 1'b1;
               next_req_brk = src_brk;
               next_req_close = 1'b1;
               next_state = S_PAR_CLOSE;
            end
         end
         S_RET_SRC_CLOSE, S_PAR_TRIP_TIE:
         begin
            if (sel_done)
               next_state = S_NORMAL;
         end
         S_FAULT:
            next_state = S_FAULT;
         default:
            next_state = S_IDLE;
      endcase
      if (req_valid == 1'b0 && sel_fail && state != S_FAULT)
         next_state = S_FAULT;
      if (abort)
      begin
         next_state = S_IDLE;
         next_req_valid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= S_IDLE;
         lost_b <= 1'b0;
         req_valid <= 1'b0;
         req_brk <= BRK_TIE;
         req_close <= 1'b0;
      end
      else
      begin
         state <= next_state;
         lost_b <= next_lost_b;
         req_valid <= next_req_valid;
         req_brk <= next_req_brk;
         req_close <= next_req_close;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         transfer_blocked <= 1'b0;
         auto_active <= 1'b0;
         transferred <= 1'b0;
         paralleled <= 1'b0;
         fault_alarm <= 1'b0;
      end
      else
      begin
         transfer_blocked <= blocked;
         auto_active <= (state != S_IDLE) && (state != S_FAULT);
         transferred <= (state == S_TRANSFERRED) || (state == S_MAINT);
         paralleled <= all_closed;
         fault_alarm <= (state == S_FAULT);
      end
   end
endmodule

//--- breaker_plant.sv
`timescale 1ns/1ps
// one electrically operated breaker: coils move the contacts after a short or long travel time
module breaker_plant #(
   parameter bit INIT = 1'b0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic close_cmd,
   input wire logic trip_cmd,
   input wire logic slow,
   output logic closed
);
   logic [3:0] cnt;
   wire moving = (close_cmd && !closed) || (trip_cmd && closed);
   wire [3:0] travel = slow ? 4'hB : 4'h2;
   // reset puts back the hand-set lineup: both sources closed, coupling open
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         closed <= INIT;
         cnt <= 4'h0;
      end
      else if (moving && cnt == travel)
      begin
         closed <= !trip_cmd;
         cnt <= 4'h0;
      end
      else
         cnt <= moving ? cnt + 4'h1 : 4'h0;
   end
endmodule

//--- auto_transfer_sequencer_chk.sv
`timescale 1ns/1ps
module auto_transfer_sequencer_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic auto_mode,
   input wire logic source_a_breaker_closed,
   input wire logic source_b_breaker_closed,
   input wire logic tie_breaker_closed,
   input wire logic source_a_breaker_tripped,
   input wire logic source_b_breaker_tripped,
   input wire logic tie_breaker_tripped,
   input wire logic source_a_breaker_connected,
   input wire logic source_b_breaker_connected,
   input wire logic tie_breaker_connected,
   input wire logic redundant_tie_fitted,
   input wire logic redundant_tie_connected,
   input wire logic redundant_tie_tripped,
   input wire logic sync_check_fitted,
   input wire logic sync_ok,
   input wire logic source_a_close,
   input wire logic source_a_trip,
   input wire logic source_b_close,
   input wire logic source_b_trip,
   input wire logic tie_close,
   input wire logic tie_trip,
   input wire logic transfer_blocked
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire permit = sync_check_fitted && sync_ok;
   wire a = source_a_breaker_closed;
   wire b = source_b_breaker_closed;
   wire t = tie_breaker_closed;
   wire blk = source_a_breaker_tripped || source_b_breaker_tripped || tie_breaker_tripped
      || !source_a_breaker_connected || !source_b_breaker_connected || !tie_breaker_connected
      || (redundant_tie_fitted && (redundant_tie_tripped || !redundant_tie_connected));
   wire [5:0] coils = {source_a_close, source_a_trip, source_b_close, source_b_trip,
      tie_close, tie_trip};
   // a close aimed at the one open breaker while the other two are shut
   wire risk = (source_a_close && !a && b && t) || (source_b_close && !b && a && t)
      || (tie_close && !t && a && b);

   chk_three_closed: assert property (!(risk && !permit && $past(risk && !permit)))
      else $error("third breaker closing without sync permit");
   chk_manual_quiet: assert property (!auto_mode [*4] |-> coils == 6'h00)
      else $error("coil driven in manual mode");
   chk_block_quiet: assert property (blk [*4] |-> coils == 6'h00)
      else $error("coil driven while transfer blocked");
   chk_block_flag: assert property ((blk ##1 blk |-> transfer_blocked)
      and (!blk ##1 !blk |-> !transfer_blocked))
      else $error("blocked flag disagrees with lockouts");
   chk_one_coil: assert property ($onehot0(coils))
      else $error("more than one coil energised");
   chk_trip_drop: assert property (source_a_trip && !a |-> ##[1:2] !source_a_trip)
      else $error("source a trip held after opening");
   chk_close_drop: assert property (tie_close && t |-> ##[1:2] !tie_close)
      else $error("coupling close held after closing");
   chk_tie_order: assert property ($rose(tie_close) |-> permit || !(a && b))
      else $error("coupling closed before a source opened");
   chk_open_return: assert property (
      ($rose(source_a_close) || $rose(source_b_close)) && !permit |-> !t)
      else $error("source closed before coupling opened");

   cover property ($rose(tie_close));
   cover property ($rose(source_a_trip));
   cover property ($rose(source_b_close) && t);
   cover property (blk ##1 transfer_blocked);
endmodule

bind auto_transfer_sequencer auto_transfer_sequencer_chk chk_u (.clk, .sys_rst, .auto_mode,
   .source_a_breaker_closed, .source_b_breaker_closed, .tie_breaker_closed,
   .source_a_breaker_tripped, .source_b_breaker_tripped, .tie_breaker_tripped,
   .source_a_breaker_connected, .source_b_breaker_connected, .tie_breaker_connected,
   .redundant_tie_fitted, .redundant_tie_connected, .redundant_tie_tripped,
   .sync_check_fitted, .sync_ok, .source_a_close, .source_a_trip, .source_b_close,
   .source_b_trip, .tie_close, .tie_trip, .transfer_blocked);

//--- tb_auto_transfer_sequencer.sv
`timescale 1ns/1ps
module tb_auto_transfer_sequencer;
   import ats_pkg::*;
   logic clk, sys_rst, auto_mode, source_a_ok, source_b_ok, slow, jam;
   logic source_a_breaker_closed, source_b_breaker_closed, tie_breaker_closed;
   logic source_a_breaker_tripped, source_b_breaker_tripped, tie_breaker_tripped;
   logic source_a_breaker_connected, source_b_breaker_connected, tie_breaker_connected;
   logic redundant_tie_fitted, redundant_tie_connected, redundant_tie_tripped;
   logic sync_check_fitted, sync_ok, closed_transition, manual_return, return_request;
   trip_sel_e trip_sel;
   test_sel_e test_sel;
   logic [15:0] transfer_delay_ms, return_delay_ms;
   logic source_a_close, source_a_trip, source_b_close, source_b_trip, tie_close, tie_trip;
   logic transfer_blocked, auto_active, transferred, paralleled, fault_alarm;
   int fail_count, comparisons, par_n, par_base;
   wire [2:0] pos = {source_a_breaker_closed, source_b_breaker_closed, tie_breaker_closed};
   wire [6:0] quiet = {source_a_close, source_a_trip, source_b_close, source_b_trip,
      tie_close, tie_trip, fault_alarm};

   auto_transfer_sequencer #(.TICK_CYCLES(4), .PARALLEL_DWELL_MS(16'h0003)) dut_u (.clk,
      .sys_rst, .auto_mode, .source_a_ok, .source_b_ok, .source_a_breaker_closed,
      .source_b_breaker_closed, .tie_breaker_closed, .source_a_breaker_tripped,
      .source_b_breaker_tripped, .tie_breaker_tripped, .source_a_breaker_connected,
      .source_b_breaker_connected, .tie_breaker_connected, .redundant_tie_fitted,
      .redundant_tie_connected, .redundant_tie_tripped, .sync_check_fitted, .sync_ok,
      .closed_transition, .manual_return, .return_request, .trip_sel, .test_sel,
      .transfer_delay_ms, .return_delay_ms, .source_a_close, .source_a_trip, .source_b_close,
      .source_b_trip, .tie_close, .tie_trip, .transfer_blocked, .auto_active, .transferred,
      .paralleled, .fault_alarm);
   breaker_plant #(.INIT(1'b1)) plant_a (.clk, .sys_rst, .close_cmd(source_a_close && !jam),
      .trip_cmd(source_a_trip), .slow, .closed(source_a_breaker_closed));
   breaker_plant #(.INIT(1'b1)) plant_b (.clk, .sys_rst, .close_cmd(source_b_close),
      .trip_cmd(source_b_trip), .slow, .closed(source_b_breaker_closed));
   breaker_plant #(.INIT(1'b0)) plant_t (.clk, .sys_rst, .close_cmd(tie_close),
      .trip_cmd(tie_trip), .slow, .closed(tie_breaker_closed));

   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
      if (paralleled === 1'b1)
         par_n <= par_n + 1;

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   // bounded wait for a breaker lineup, then the coils must have gone quiet
   task wait_pos(input logic [2:0] exp);
      int n;
      n = 0;
      while (pos !== exp && n < 3000)
      begin
         cyc(1);
         n++;
      end
      if (pos !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t lineup %0h never reached", $time, exp);
         wrap_up;
      end
      cyc(6);
      chk(16'(quiet), 16'h0000, "coils left on");
   endtask
   task do_reset;
      {auto_mode, slow, jam, closed_transition, manual_return, return_request} = 6'h00;
      {source_a_ok, source_b_ok} = 2'h3;
      {source_a_breaker_tripped, source_b_breaker_tripped, tie_breaker_tripped} = 3'h0;
      {source_a_breaker_connected, source_b_breaker_connected, tie_breaker_connected} = 3'h7;
      {redundant_tie_fitted, redundant_tie_connected, redundant_tie_tripped} = 3'h2;
      {sync_check_fitted, sync_ok} = 2'h0;
      trip_sel = TRIP_NONE;
      test_sel = TEST_NORMAL;
      transfer_delay_ms = 16'h0001;
      return_delay_ms = 16'h0001;
      sys_rst = 1;
      cyc(12);
      sys_rst = 0;
      cyc(2);
      auto_mode = 1;
      cyc(4);
   endtask

   task sc_loss_a;
      int n;
      do_reset;
      transfer_delay_ms = 16'h0005;
      return_delay_ms = 16'h0003;
      source_a_ok = 0;
      cyc(12);
      source_a_ok = 1;
      cyc(40);
      chk(16'(pos), 16'h0006, "short dip caused transfer");
      source_a_ok = 0;
      n = 0;
      while (source_a_trip !== 1'b1 && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk(16'(n >= 16 && n <= 30), 16'h0001, "transfer delay length");
      wait_pos(3'b011);
      chk(16'(transferred), 16'h0001, "not flagged transferred");
      source_a_ok = 1;
      wait_pos(3'b110);
      chk(16'(transferred), 16'h0000, "still flagged transferred");
      // a jammed closing mechanism must end in the fault latch, not a hang
      jam = 1;
      source_a_ok = 0;
      wait_pos(3'b011);
      source_a_ok = 1;
      cyc(2200);
      chk(16'({pos, fault_alarm, auto_active}), 16'h000A, "stuck breaker not flagged");
      $display("test loss_a done");
   endtask

   task sc_test_switch;
      for (int i = 0; i < 2; i++)
      begin
         do_reset;
         {closed_transition, sync_check_fitted, sync_ok} = 3'h7;
         test_sel = i ? TEST_EMULATE_B_LOSS : TEST_EMULATE_A_LOSS;
         wait_pos(i ? 3'b101 : 3'b011);
         par_base = par_n;
         test_sel = TEST_NORMAL;
         wait_pos(3'b110);
         chk(16'(par_n - par_base >= 8), 16'h0001, "no parallel dwell on return");
      end
      $display("test test_switch done");
   endtask

   task sc_maint;
      for (int i = 0; i < 2; i++)
      begin
         do_reset;
         slow = 1;
         sync_check_fitted = 1;
         trip_sel = i ? TRIP_B : TRIP_A;
         par_base = par_n;
         cyc(60);
         chk(16'(pos), 16'h0006, "maintenance without sync");
         sync_ok = 1;
         wait_pos(i ? 3'b101 : 3'b011);
         chk(16'(transferred), 16'h0001, "maintenance not flagged");
         chk(16'(par_n - par_base >= 8), 16'h0001, "no dwell before trip");
         par_base = par_n;
         trip_sel = TRIP_TIE;
         wait_pos(3'b110);
         chk(16'(par_n - par_base >= 8), 16'h0001, "no dwell before coupling trip");
      end
      $display("test maint done");
   endtask

   task sc_block;
      for (int k = 0; k < 5; k++)
      begin
         do_reset;
         case (k)
            0: tie_breaker_tripped = 1;
            1: source_b_breaker_connected = 0;
            2: {redundant_tie_fitted, redundant_tie_tripped} = 2'h3;
            3: {redundant_tie_fitted, redundant_tie_connected} = 2'h2;
            default: redundant_tie_fitted = 1;
         endcase
         source_a_ok = 0;
         cyc(80);
         chk(16'(pos), (k == 4) ? 16'h3 : 16'h6, "transfer despite lockout");
         chk(16'(transfer_blocked), 16'(k != 4), "blocked flag");
      end
      $display("test block done");
   endtask

   task sc_manual;
      do_reset;
      auto_mode = 0;
      source_a_ok = 0;
      cyc(80);
      chk(16'(pos), 16'h0006, "transfer in manual mode");
      chk(16'(auto_active), 16'h0000, "active in manual mode");
      do_reset;
      {manual_return, closed_transition, sync_check_fitted, sync_ok} = 4'hF;
      source_a_ok = 0;
      wait_pos(3'b011);
      source_a_ok = 1;
      cyc(60);
      chk(16'(pos), 16'h0003, "returned without request");
      par_base = par_n;
      return_request = 1;
      wait_pos(3'b110);
      return_request = 0;
      chk(16'(par_n - par_base), 16'h0000, "manual return paralleled");
      $display("test manual done");
   endtask

   initial
   begin
      fail_count = 0;
      comparisons = 0;
      do_reset;
      sc_loss_a;
      sc_test_switch;
      sc_maint;
      sc_block;
      sc_manual;
      wrap_up;
   end
endmodule
